// ---- dv/rta_panel_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************
// Panel and converter model.
// ****************
module rta_panel_model (
  // Clock.
  input wire logic clk,
  // Bias switches and converter controls.
  input wire logic [3:0] drive_ref,
  input wire logic [3:0] drive_gnd,
  input wire logic wiper_gnd,
  input wire logic pullup_en,
  input wire logic [1:0] adc_sel,
  input wire logic adc_start,
  // Bench controls.
  input wire logic five,
  input wire logic touch,
  input wire logic slow,
  // Answers.
  output logic adc_done,
  output logic [11:0] adc_data,
  output logic pen_cmp
);
  logic [3:0] wait_cnt; // Cycles left before the answer.
  logic ok; // Sense wire matches the bias pattern.
  // The comparator only trips with a ground path and the pull-up on.
  assign pen_cmp = touch & pullup_en & (five ? wiper_gnd : drive_gnd[3]);
  // A wrong sense wire reads zero, so steering faults show in results.
  assign ok = five ? (adc_sel == 2'h3) :
    (|drive_ref[1:0]) ? (adc_sel == 2'h1 || adc_sel == 2'h2) :
    (adc_sel == 2'h0);
  initial begin
    wait_cnt = 4'h0;
    adc_done = 1'b0;
    adc_data = 12'h5a5;
  end
  // Data toggles outside the done pulse, as a real bus would not hold.
  always @(posedge clk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (adc_start) begin
      wait_cnt <= slow ? 4'h9 : 4'h1;
    end else if (wait_cnt == 4'h1) begin
      adc_done <= 1'b1;
      adc_data <= ok ? 12'hfff : 12'h000;
      wait_cnt <= 4'h0;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule : rta_panel_model
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk, rst_n, reg_wr, reg_rd, wiper_gnd, pu_en, adc_start, adc_done;
  logic pen_cmp, irq, prox_hold, five, touch, slow;
  logic [3:0] reg_addr, drive_ref, drive_gnd;
  logic [15:0] reg_wdata, reg_rdata, s;
  logic [1:0] pu, adc_sel;
  logic [11:0] adc_data;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  rta_touch_ctrl u_rta_touch_ctrl (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .drive_ref(drive_ref), .drive_gnd(drive_gnd), .wiper_gnd(wiper_gnd),
    .detect_pullup_en(pu_en), .detect_pullup(pu), .adc_sel(adc_sel),
    .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
    .pen_cmp(pen_cmp), .irq(irq), .prox_hold(prox_hold));
  rta_panel_model u_rta_panel_model (.clk(clk), .drive_ref(drive_ref),
    .drive_gnd(drive_gnd), .wiper_gnd(wiper_gnd), .pullup_en(pu_en),
    .adc_sel(adc_sel), .adc_start(adc_start), .five(five), .touch(touch),
    .slow(slow), .adc_done(adc_done), .adc_data(adc_data), .pen_cmp(pen_cmp));
  // Compare and count.
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Register write, one strobe cycle.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Register read; data stand only in the following cycle.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  // Poll one status bit, bounded.
  task automatic poll(input int b, input logic v);
    for (int i = 0; i < 2000; i++) begin
      rd(4'h2, s);
      if (s[b] === v) break;
    end
  endtask : poll
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // Reset values and an unmapped index.
  task automatic t_reset;
    rd(4'h0, s);
    check("ctrl", s, 16'h0798);
    rd(4'h1, s);
    check("delay", s, 16'h0108);
    rd(4'hc, s);
    check("unmapped", s, 16'h0000);
    check("bias", {drive_ref, drive_gnd, 7'h00, irq}, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  // Detect-only: touch then release, with events masked in.
  task automatic t_detect;
    wr(4'h3, 16'h0006);
    wr(4'h0, 16'h07fa);
    for (int i = 0; i < 50 && pu_en !== 1'b1; i++) @(negedge clk);
    check("pullup", {pu, pu_en, drive_gnd[3]}, 16'h000f);
    touch = 1'b1;
    poll(0, 1'b1);
    check("touch st", s[1:0], 16'h0003);
    check("hold", prox_hold, 16'h0001);
    check("irq set", irq, 16'h0001);
    wr(4'h2, 16'h0002);
    touch = 1'b0;
    poll(0, 1'b0);
    check("release st", s[2:0], 16'h0004);
    check("hold off", {irq, prox_hold}, 16'h0002);
    wr(4'h0, 16'h0180);
    wr(4'h2, 16'h0006);
    $display("test detect done");
  endtask : t_detect
  // Detect-then-convert on X and Y with a chosen filter.
  task automatic t_conv(input logic fw, input logic [1:0] f, input logic sl);
    logic [15:0] e;
    e = (f == 2'h0) ? 16'h0fff : 16'h0fef;
    five = fw;
    slow = sl;
    touch = 1'b1;
    wr(4'h1, 16'h0210);
    wr(4'h0, {5'h00, fw ? 4'hf : 4'h3, 2'h0, f, 2'h2, fw});
    poll(3, 1'b1);
    check("conv evt", s[3], 16'h0001);
    rd(4'h4, s);
    check("res x", s, e);
    rd(4'h5, s);
    check("res y", s, e);
    rd(4'h6, s);
    check("res z1", s, 16'h0000);
    wr(4'h0, 16'h0180);
    touch = 1'b0;
    poll(4, 1'b0);
    check("idle", s[4], 16'h0000);
    wr(4'h2, 16'h000e);
    $display("test conv done");
  endtask : t_conv
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    {rst_n, reg_wr, reg_rd, five, touch, slow} = 6'h00;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_detect();
    for (int f = 0; f < 4; f++) t_conv(1'b0, f[1:0], f[0]);
    t_conv(1'b1, 2'h3, 1'b1);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire

// ---- inc/rta_map.svh ----
`ifndef RTA_MAP_SVH
`define RTA_MAP_SVH

// ****************************************************************
// Register offsets on the plain register port.
// ****************************************************************
`define RTA_OFS_CTRL 4'h0
`define RTA_OFS_DELAY 4'h1
`define RTA_OFS_STATUS 4'h2
`define RTA_OFS_IRQ_MASK 4'h3
`define RTA_OFS_RESULT_X 4'h4
`define RTA_OFS_RESULT_Z2 4'h7

// ****************************************************************
// Field positions.
// ****************************************************************
`define RTA_CTRL_PANEL 0
`define RTA_CTRL_MODE_LO 1
`define RTA_CTRL_FILTER_ORDER_SELECT_LO 3
`define RTA_CTRL_PULL_LO 5
`define RTA_CTRL_CHAN_LO 7
`define RTA_DLY_BIAS_LO 0
`define RTA_DLY_REP_LO 8
`define RTA_ST_TOUCH 0
`define RTA_ST_EVT_TOUCH 1
`define RTA_ST_EVT_RELEASE 2
`define RTA_ST_EVT_CONV 3
`define RTA_ST_BUSY 4

// ****************************************************************
// Reset values and arithmetic constants.
// ****************************************************************
`define RTA_RST_CTRL 16'h0798
`define RTA_RST_DELAY 16'h0108
`define RTA_RST_IRQ_MASK 3'h0
`define RTA_FULL_SCALE 27'h0000fff
`define RTA_SCALE_NUM 27'h0000fef
`define RTA_DET_SHIFT 3

`endif

// ---- inc/rta_pkg.sv ----
package rta_pkg;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DET_BIAS = 4'h1,
    ST_DET_SAMPLE = 4'h2,
    ST_CH_BIAS = 4'h3,
    ST_CONV = 4'h4,
    ST_WAIT = 4'h5,
    ST_SETTLE = 4'h6,
    ST_STORE = 4'h7
  } rta_state_t;

  // Operating modes.
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_DETECT = 2'h1,
    MODE_CONVERT = 2'h2,
    MODE_SPARE = 2'h3
  } rta_mode_t;

  // Measurement channels.
  typedef enum logic [1:0] {
    CH_X = 2'h0,
    CH_Y = 2'h1,
    CH_Z1 = 2'h2,
    CH_Z2 = 2'h3
  } rta_chan_t;

  // Converter input selection.
  typedef enum logic [1:0] {
    SNS_XP = 2'h0,
    SNS_YP = 2'h1,
    SNS_YM = 2'h2,
    SNS_WIPER = 2'h3
  } rta_sense_t;

  // Filter state.
  typedef struct packed {
    logic [2:0] count;
    logic [14:0] sum;
    logic [11:0] max1;
    logic [11:0] max2;
    logic [11:0] min1;
    logic [11:0] min2;
    logic calc;
    logic done;
    logic [11:0] result;
  } rta_filter_order_select_t;

  // Sequencer and register state.
  typedef struct packed {
    logic five_wire;
    rta_mode_t mode;
    logic [1:0] filter_order_select;
    logic [1:0] pull_sel;
    logic [3:0] chan_mask;
    logic [7:0] bias_dly;
    logic [7:0] rep_dly;
    logic touch;
    logic evt_touch;
    logic evt_release;
    logic evt_conv;
    logic [2:0] irq_mask;
    logic [3:0][11:0] result;
    rta_state_t st;
    logic [7:0] cnt;
    rta_chan_t chan;
    logic [2:0] nsmp;
    logic cmp_meta;
    logic cmp_sync;
    logic [3:0] drv_ref;
    logic [3:0] drv_gnd;
    logic wiper_gnd;
    logic pull_en;
    rta_sense_t sense;
    logic adc_start;
    logic [15:0] rdata;
    logic irq;
  } rta_main_t;

endpackage : rta_pkg

// ---- logic/rta_filter.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rta_map.svh"

module rta_filter (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Sample stream.
  input wire logic clear,
  input wire logic sample_valid,
  input wire logic [11:0] sample,
  input wire logic [1:0] order,
  // Consolidated answer.
  output logic done,
  output logic [11:0] result
);

  rta_pkg::rta_filter_order_select_t s, next_s;

  // Averages the kept sum and applies the 4079/4095 scaling; order zero passes the sum through unscaled.
  function automatic logic [11:0] scale(input logic [14:0] sum, input logic [1:0] ord);
    logic [26:0] prod;
    logic [26:0] div;
    prod = {12'h000, sum} * `RTA_SCALE_NUM;
    div = (ord == 2'h2) ? `RTA_FULL_SCALE * 27'h0000005 : `RTA_FULL_SCALE * 27'h0000003;
    scale = (ord == 2'h0) ? sum[11:0] : 12'(prod / div);
  endfunction : scale

  // ********************************************************
  // Running sum and the two largest and smallest samples.
  // ********************************************************
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (clear) begin
      next_s.count = 3'h0;
      next_s.sum = 15'h0000;
      next_s.max1 = 12'h000;
      next_s.max2 = 12'h000;
      next_s.min1 = 12'hfff;
      next_s.min2 = 12'hfff;
      next_s.calc = 1'b0;
    end else if (sample_valid) begin
      // Tracking extremes on the fly avoids storing and sorting seven words.
      next_s.count = s.count + 3'h1;
      next_s.sum = s.sum + {3'h0, sample};
      if (sample >= s.max1) begin
        next_s.max1 = sample;
        next_s.max2 = s.max1;
      end else if (sample > s.max2) begin
        next_s.max2 = sample;
      end
      if (sample <= s.min1) begin
        next_s.min1 = sample;
        next_s.min2 = s.min1;
      end else if (sample < s.min2) begin
        next_s.min2 = sample;
      end
      next_s.calc = (s.count + 3'h1) == {order, 1'b1};
    end else if (s.calc) begin
      // Order three keeps only the middle three of seven.
      if (order == 2'h3) begin
        next_s.result = scale(s.sum - {3'h0, s.max1} - {3'h0, s.max2}
                              - {3'h0, s.min1} - {3'h0, s.min2}, order);
      end else begin
        next_s.result = scale(s.sum, order);
      end
      next_s.done = 1'b1;
      next_s.calc = 1'b0;
    end
  end

  // Registers the filter state.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign result = s.result;

  // The answer follows the last sample by exactly two edges.
  a_filter_done_time: assert property (@(posedge clk) disable iff (!rst_n)
    (sample_valid && !clear && (s.count + 3'h1) == {order, 1'b1}) |=> ##1 done)
    else $error("filter answer not two cycles after last sample");

  // Averaged answers never pass the scaled full scale.
  a_filter_range: assert property (@(posedge clk) disable iff (!rst_n)
    (done && order != 2'h0) |-> result <= 12'hfef)
    else $error("filter answer above scaled full scale");

endmodule : rta_filter

`default_nettype wire

// ---- logic/rta_touch_ctrl.sv ----
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "rta_map.svh"

module rta_touch_ctrl (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Panel bias switches; pin 0 is X+ or the bottom right corner.
  output logic [3:0] drive_ref,
  output logic [3:0] drive_gnd,
  output logic wiper_gnd,
  output logic detect_pullup_en,
  output logic [1:0] detect_pullup,
  // Converter.
  output logic [1:0] adc_sel,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  input wire logic pen_cmp,
  // Status towards the system.
  output logic irq,
  output logic prox_hold
);

  // ****************************************************************
  // State and local helpers.
  // ****************************************************************
  rta_pkg::rta_main_t s, next_s;
  // Filter hand-shake: clear and valid driven from the sequencer each cycle, done and result from the filter.
  logic f_clear;
  logic f_valid;
  logic f_done;
  logic [11:0] f_result;
  // Per-cycle decode of the register port, sequencer event sets and channel search.
  logic wr_status;
  logic [2:0] set_evt;
  logic [2:0] next_chan;

  // A zero delay still waits one tick so the bias is never skipped.
  function automatic logic [7:0] ticks(input logic [7:0] v);
    ticks = (v == 8'h00) ? 8'h01 : v;
  endfunction : ticks

  // Finds the first enabled channel at or after a start index.
  function automatic logic [2:0] find_chan(input logic [3:0] mask, input logic [2:0] from,
                                           input logic five);
    logic [3:0] ok;
    find_chan = 3'h0;
    ok = five ? {2'b00, mask[1:0]} : mask;
    for (int i = 3; i >= 0; i--) begin
      if (ok[i] && 3'(i) >= from) begin
        find_chan = {1'b1, 2'(i)};
      end
    end
  endfunction : find_chan

  // Bias pattern {ref, gnd, wiper} for a conversion channel.
  function automatic logic [8:0] chan_bias(input rta_pkg::rta_chan_t ch, input logic five);
    chan_bias = 9'h000;
    if (five) begin
      // Opposite corner pairs of the lower sheet.
      if (ch == rta_pkg::CH_X) begin
        chan_bias = {4'b0101, 4'b1010, 1'b0};
      end else begin
        chan_bias = {4'b0110, 4'b1001, 1'b0};
      end
    end else begin
      case (ch)
        rta_pkg::CH_X: chan_bias = {4'b0001, 4'b0010, 1'b0};
        rta_pkg::CH_Y: chan_bias = {4'b0100, 4'b1000, 1'b0};
        default: chan_bias = {4'b0100, 4'b0010, 1'b0};
      endcase
    end
  endfunction : chan_bias

  // Converter input for a channel.
  function automatic rta_pkg::rta_sense_t chan_sense(input rta_pkg::rta_chan_t ch,
                                                     input logic five);
    if (five) begin
      chan_sense = rta_pkg::SNS_WIPER;
    end else begin
      case (ch)
        rta_pkg::CH_X: chan_sense = rta_pkg::SNS_YP;
        rta_pkg::CH_Z2: chan_sense = rta_pkg::SNS_YM;
        default: chan_sense = rta_pkg::SNS_XP;
      endcase
    end
  endfunction : chan_sense

  // ****************************************************************
  // Filter.
  // ****************************************************************
  rta_filter u_filter (
    .clk(clk),
    .rst_n(rst_n),
    .clear(f_clear),
    .sample_valid(f_valid),
    .sample(adc_data),
    .order(s.filter_order_select),
    .done(f_done),
    .result(f_result)
  );

  // ****************************************************************
  // Next-state logic: registers, sequencer, panel switches.
  // ****************************************************************
  always_comb begin
    next_s = s;
    f_clear = 1'b0;
    f_valid = 1'b0;
    set_evt = 3'h0;
    next_chan = 3'h0;
    next_s.adc_start = 1'b0;
    // Comparator passes two flops before anything looks at it.
    next_s.cmp_meta = pen_cmp;
    next_s.cmp_sync = s.cmp_meta;
    wr_status = reg_wr && reg_addr == `RTA_OFS_STATUS;

    // Register writes.
    if (reg_wr && reg_addr == `RTA_OFS_CTRL) begin
      next_s.five_wire = reg_wdata[`RTA_CTRL_PANEL];
      next_s.mode = rta_pkg::rta_mode_t'(reg_wdata[`RTA_CTRL_MODE_LO +: 2]);
      next_s.filter_order_select = reg_wdata[`RTA_CTRL_FILTER_ORDER_SELECT_LO +: 2];
      next_s.pull_sel = reg_wdata[`RTA_CTRL_PULL_LO +: 2];
      next_s.chan_mask = reg_wdata[`RTA_CTRL_CHAN_LO +: 4];
    end
    if (reg_wr && reg_addr == `RTA_OFS_DELAY) begin
      next_s.bias_dly = reg_wdata[`RTA_DLY_BIAS_LO +: 8];
      next_s.rep_dly = reg_wdata[`RTA_DLY_REP_LO +: 8];
    end
    if (reg_wr && reg_addr == `RTA_OFS_IRQ_MASK) begin
      next_s.irq_mask = reg_wdata[`RTA_ST_EVT_TOUCH +: 3];
    end

    // Sequencer.
    case (s.st)
      rta_pkg::ST_IDLE: begin
        next_s.cnt = 8'h00;
        if (s.mode == rta_pkg::MODE_DETECT || s.mode == rta_pkg::MODE_CONVERT) begin
          next_s.st = rta_pkg::ST_DET_BIAS;
        end
      end
      rta_pkg::ST_DET_BIAS: begin
        next_s.cnt = s.cnt + 8'h01;
        if (s.cnt + 8'h01 >= ticks(s.bias_dly >> `RTA_DET_SHIFT)) begin
          next_s.cnt = 8'h00;
          next_s.st = rta_pkg::ST_DET_SAMPLE;
        end
      end
      rta_pkg::ST_DET_SAMPLE: begin
        // The synchroniser lags two edges, so the verdict waits for the second cycle.
        next_s.cnt = 8'h01;
        if (s.cnt != 8'h00) begin
          next_s.cnt = 8'h00;
          // Touch and release each raise their own sticky event.
          next_s.touch = s.cmp_sync;
          set_evt[0] = s.cmp_sync && !s.touch;
          set_evt[1] = !s.cmp_sync && s.touch;
          next_chan = find_chan(s.chan_mask, 3'h0, s.five_wire);
          if (s.mode == rta_pkg::MODE_CONVERT && s.cmp_sync && next_chan[2]) begin
            next_s.chan = rta_pkg::rta_chan_t'(next_chan[1:0]);
            next_s.st = rta_pkg::ST_CH_BIAS;
          end else if (s.mode == rta_pkg::MODE_DETECT || s.mode == rta_pkg::MODE_CONVERT) begin
            next_s.st = rta_pkg::ST_DET_BIAS;
          end else begin
            next_s.st = rta_pkg::ST_IDLE;
          end
        end
      end
      rta_pkg::ST_CH_BIAS: begin
        next_s.cnt = s.cnt + 8'h01;
        if (s.cnt + 8'h01 >= ticks(s.bias_dly)) begin
          next_s.st = rta_pkg::ST_CONV;
          next_s.nsmp = 3'h0;
          f_clear = 1'b1;
        end
      end
      rta_pkg::ST_CONV: begin
        next_s.adc_start = 1'b1;
        next_s.st = rta_pkg::ST_WAIT;
      end
      rta_pkg::ST_WAIT: begin
        next_s.cnt = 8'h00;
        if (adc_done) begin
          f_valid = 1'b1;
          next_s.nsmp = s.nsmp + 3'h1;
          if (s.nsmp + 3'h1 == {s.filter_order_select, 1'b1}) begin
            next_s.st = rta_pkg::ST_STORE;
          end else begin
            next_s.st = rta_pkg::ST_SETTLE;
          end
        end
      end
      rta_pkg::ST_SETTLE: begin
        next_s.cnt = s.cnt + 8'h01;
        if (s.cnt + 8'h01 >= ticks(s.rep_dly)) begin
          next_s.st = rta_pkg::ST_CONV;
        end
      end
      rta_pkg::ST_STORE: begin
        next_s.cnt = 8'h00;
        if (f_done) begin
          // Only raw codes are kept; resistance math is left to software.
          next_s.result[s.chan] = f_result;
          next_chan = find_chan(s.chan_mask, {1'b0, s.chan} + 3'h1, s.five_wire);
          if (next_chan[2]) begin
            next_s.chan = rta_pkg::rta_chan_t'(next_chan[1:0]);
            next_s.st = rta_pkg::ST_CH_BIAS;
          end else begin
            set_evt[2] = 1'b1;
            next_s.st = rta_pkg::ST_DET_BIAS;
          end
        end
      end
      default: begin
        next_s.st = rta_pkg::ST_IDLE;
      end
    endcase

    // Sticky events: a set in the clearing cycle wins.
    next_s.evt_touch = (s.evt_touch && !(wr_status && reg_wdata[`RTA_ST_EVT_TOUCH]))
                       || set_evt[0];
    next_s.evt_release = (s.evt_release && !(wr_status && reg_wdata[`RTA_ST_EVT_RELEASE]))
                         || set_evt[1];
    next_s.evt_conv = (s.evt_conv && !(wr_status && reg_wdata[`RTA_ST_EVT_CONV]))
                      || set_evt[2];
    next_s.irq = |({s.evt_conv, s.evt_release, s.evt_touch} & s.irq_mask);

    // Switch pattern follows the state being entered, so bias and state line up.
    next_s.drv_ref = 4'h0;
    next_s.drv_gnd = 4'h0;
    next_s.wiper_gnd = 1'b0;
    next_s.pull_en = 1'b0;
    next_s.sense = rta_pkg::SNS_XP;
    case (next_s.st)
      rta_pkg::ST_DET_BIAS, rta_pkg::ST_DET_SAMPLE: begin
        next_s.pull_en = 1'b1;
        if (next_s.five_wire) begin
          next_s.wiper_gnd = 1'b1;
        end else begin
          next_s.drv_gnd = 4'b1000;
        end
      end
      rta_pkg::ST_CH_BIAS, rta_pkg::ST_CONV, rta_pkg::ST_WAIT, rta_pkg::ST_SETTLE: begin
        {next_s.drv_ref, next_s.drv_gnd, next_s.wiper_gnd} =
          chan_bias(next_s.chan, next_s.five_wire);
        next_s.sense = chan_sense(next_s.chan, next_s.five_wire);
      end
      default: begin
        next_s.pull_en = 1'b0;
      end
    endcase

    // Read data stands only in the cycle after the strobe.
    next_s.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `RTA_OFS_CTRL: next_s.rdata = {5'h00, s.chan_mask, s.pull_sel, s.filter_order_select, s.mode,
                                       s.five_wire};
        `RTA_OFS_DELAY: next_s.rdata = {s.rep_dly, s.bias_dly};
        `RTA_OFS_STATUS: next_s.rdata = {11'h000, s.st != rta_pkg::ST_IDLE, s.evt_conv,
                                         s.evt_release, s.evt_touch, s.touch};
        `RTA_OFS_IRQ_MASK: next_s.rdata = {12'h000, s.irq_mask, 1'b0};
        default: begin
          if (reg_addr >= `RTA_OFS_RESULT_X && reg_addr <= `RTA_OFS_RESULT_Z2) begin
            next_s.rdata = {4'h0, s.result[reg_addr[1:0]]};
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.five_wire <= 1'(`RTA_RST_CTRL >> `RTA_CTRL_PANEL);
      s.filter_order_select <= 2'(`RTA_RST_CTRL >> `RTA_CTRL_FILTER_ORDER_SELECT_LO);
      s.pull_sel <= 2'(`RTA_RST_CTRL >> `RTA_CTRL_PULL_LO);
      s.chan_mask <= 4'(`RTA_RST_CTRL >> `RTA_CTRL_CHAN_LO);
      s.bias_dly <= 8'(`RTA_RST_DELAY >> `RTA_DLY_BIAS_LO);
      s.rep_dly <= 8'(`RTA_RST_DELAY >> `RTA_DLY_REP_LO);
      s.irq_mask <= `RTA_RST_IRQ_MASK;
    end else begin
      s <= next_s;
    end
  end

  // Every output comes straight from the state register.
  assign reg_rdata = s.rdata;
  assign drive_ref = s.drv_ref;
  assign drive_gnd = s.drv_gnd;
  assign wiper_gnd = s.wiper_gnd;
  assign detect_pullup_en = s.pull_en;
  assign detect_pullup = s.pull_sel;
  assign adc_sel = s.sense;
  assign adc_start = s.adc_start;
  assign irq = s.irq;
  assign prox_hold = s.touch;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  sequence s_bias_done;
    s.st == rta_pkg::ST_CH_BIAS && s.cnt + 8'h01 >= ticks(s.bias_dly);
  endsequence
  sequence s_start_conv;
    s.st == rta_pkg::ST_CONV ##1 adc_start;
  endsequence

  a_conv_after_bias: assert property (@(posedge clk) disable iff (!rst_n)
    s_bias_done |=> s_start_conv)
    else $error("conversion did not follow bias time");

  a_det_bias_time: assert property (@(posedge clk) disable iff (!rst_n)
    (s.st == rta_pkg::ST_DET_SAMPLE && $past(s.st) == rta_pkg::ST_DET_BIAS)
    |-> $past(s.cnt) + 8'h01 == ticks(s.bias_dly >> `RTA_DET_SHIFT))
    else $error("detection bias length wrong");

  a_no_z_five: assert property (@(posedge clk) disable iff (!rst_n)
    (s.five_wire && s.st == rta_pkg::ST_CH_BIAS) |-> !s.chan[1])
    else $error("pressure channel on five-wire panel");

  a_pullup_alone: assert property (@(posedge clk) disable iff (!rst_n)
    detect_pullup_en |-> drive_ref == 4'h0 && (wiper_gnd || drive_gnd == 4'b1000))
    else $error("detect bias pattern wrong");

  a_touch_event: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s.touch) |-> s.evt_touch ##1 (irq == s.irq_mask[0] || !s.evt_touch))
    else $error("touch did not raise event");

  a_release_event: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(s.touch) |-> s.evt_release)
    else $error("release did not raise event");

  a_read_window: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");

  a_settle_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (s.st == rta_pkg::ST_SETTLE && s.cnt + 8'h01 < ticks(s.rep_dly)) |=> !adc_start)
    else $error("conversion during settling");

  a_detect_only: assert property (@(posedge clk) disable iff (!rst_n)
    (s.mode == rta_pkg::MODE_DETECT && s.st == rta_pkg::ST_DET_SAMPLE)
    |=> s.st != rta_pkg::ST_CH_BIAS)
    else $error("conversion in detect-only mode");

endmodule : rta_touch_ctrl

`default_nettype wire
